/* inc/data_space_pkg.sv */
package data_space_pkg;

    // Address space layout
    localparam logic [7:0] SFR_BASE        = 8'h80;
    localparam logic [7:0] BIT_ZONE_BASE   = 8'h20;
    localparam int         RAM_DEPTH       = 256;
    localparam int         BANK_SHIFT      = 3;

    // Special function register offsets
    localparam logic [7:0] PORT0_ADDR      = 8'h80;
    localparam logic [7:0] SP_ADDR         = 8'h81;
    localparam logic [7:0] DPL0_ADDR       = 8'h82;
    localparam logic [7:0] DPH0_ADDR       = 8'h83;
    localparam logic [7:0] PTR2_LO_ADDR    = 8'h84;
    localparam logic [7:0] PTR2_HI_ADDR    = 8'h85;
    localparam logic [7:0] PSEL_ADDR       = 8'h86;
    localparam logic [7:0] PORT1_ADDR      = 8'h90;
    localparam logic [7:0] PORT2_ADDR      = 8'hA0;
    localparam logic [7:0] PORT3_ADDR      = 8'hB0;
    localparam logic [7:0] PSW_ADDR        = 8'hD0;
    localparam logic [7:0] ACC_ADDR        = 8'hE0;
    localparam logic [7:0] BREG_ADDR       = 8'hF0;

    // Reset values and the read value of unimplemented registers
    localparam logic [7:0] SP_RESET        = 8'h07;
    localparam logic [7:0] ZERO_RESET      = 8'h00;
    localparam logic [7:0] UNIMPL_READ     = 8'hFF;

    // Field positions
    localparam int         PSEL_BIT        = 0;
    localparam int         PSW_BANK_LSB    = 3;
    localparam int         PSW_PARITY      = 0;

    // Access kinds presented by the execution unit
    typedef enum logic [2:0] {
        ACC_NONE,
        ACC_DIRECT,
        ACC_INDIRECT,
        ACC_BIT,
        ACC_PUSH,
        ACC_POP
    } access_kind_e;

endpackage : data_space_pkg

/* hdl/data_space.sv */
`timescale 1ns/1ps
// Contract
// - Core holds a 256-byte scratchpad memory of 8-bit bytes.
// - Addresses 80h-FFh reach special registers by direct access only.
// - Indirect access always hits scratchpad; direct below 80h too.
// - Bytes 00h-1Fh are four register banks; status bits pick one.
// - Working registers zero and one of active bank act as pointers.
// - Bytes 20h-2Fh are bit addressable; bit n sits in byte 20h+n/8.
// - Special registers at addresses ending 0 or 8 allow bit writes.
// - Bit versus byte access decided by instruction kind only.
// - Push increments pointer then writes; pop reads then decrements.
// - Stack pointer at 81h resets to 07h, freely read and written.
// - Calls and interrupt entries push return address via stack pointer.
// - Stack may start anywhere software sets; depth limited by memory.
// - Unimplemented special registers read as ones; select register bits 7:1 read zero.
// - Unused special addresses are exported to user logic.
// - Port registers 80h, 90h, A0h, B0h are served by user logic.
// - Primary pointer low byte at 82h resets 00h, free access.
// - Primary pointer high byte at 83h resets 00h, free access.
// - Select bit 0 set makes pointer instructions use second pair.
// - Second pair is plain storage when not selected.
// - External data moves take address from active 16-bit pointer.
// - Code fetches address a separate 64K program space.
// - Secondary operand register feeds multiply and divide, else storage.
// - Status word holds carry, aux carry, overflow, parity, flags, bank.
// - Stack pointer and pointer bytes need no protection sequence.
// - Second pointer high byte at 85h resets 00h, free access.
// - Select register at 86h resets 00h; bits 7:1 read zero.
module data_space (
    input  wire logic                       ref_clk,
    input  wire logic                       rst_b,
    input  wire data_space_pkg::access_kind_e acc_kind,
    input  wire logic                       acc_write,
    input  wire logic [7:0]                 acc_addr,
    input  wire logic                       acc_use_reg,
    input  wire logic                       acc_reg_sel,
    input  wire logic [2:0]                 acc_bit_sel,
    input  wire logic [7:0]                 acc_wdata,
    input  wire logic                       acc_bit_wval,
    input  wire logic [7:0]                 alu_psw_in,
    input  wire logic                       alu_psw_we,
    input  wire logic [7:0]                 alu_acc_in,
    input  wire logic                       alu_acc_we,
    input  wire logic                       active_data_pointer_inc,
    input  wire logic [15:0]                pc_in,
    input  wire logic [7:0]                 ext_sfr_rdata,
    input  wire logic                       ext_sfr_hit,
    output logic [7:0]                      rdata,
    output logic                            rbit,
    output logic [15:0]                     xdata_addr,
    output logic [15:0]                     code_addr,
    output logic [7:0]                      mul_operand,
    output logic [7:0]                      acc_value,
    output logic [7:0]                      psw_value,
    output logic                            ext_sfr_req,
    output logic                            ext_sfr_we,
    output logic [7:0]                      ext_sfr_addr,
    output logic [7:0]                      ext_sfr_wdata
);
    import data_space_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Storage
    logic [7:0]  scratch_mem [RAM_DEPTH];
    logic [7:0]  stack_top_pointer_ff;
    logic [7:0]  data_pointer_low_primary_ff;
    logic [7:0]  data_pointer_high_primary_ff;
    logic [7:0]  data_pointer_low_secondary_ff;
    logic [7:0]  data_pointer_high_secondary_ff;
    logic        pointer_select_ff;
    logic [7:0]  program_status_word_ff;
    logic [7:0]  accumulator_register_ff;
    logic [7:0]  operand_b_ff;

    logic [7:0]  bank_base;
    logic [7:0]  ind_ptr;
    logic [7:0]  ram_addr;
    logic        ram_sel;
    logic        sfr_sel;
    logic        sfr_internal;
    logic [7:0]  sfr_addr;
    logic [7:0]  sfr_rd;
    logic [7:0]  byte_rd;
    logic [7:0]  nxt_byte;
    logic        is_write;
    logic        bit_ok;
    logic [7:0]  sp_plus;
    logic [15:0] active_data_pointer;

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    // Bank base is n*8, pointer register picked from the active bank
    assign bank_base = {3'h0, program_status_word_ff[PSW_BANK_LSB +: 2], 3'h0};
    assign ind_ptr   = scratch_mem[bank_base | {7'h00, acc_reg_sel}];
    assign sp_plus   = stack_top_pointer_ff + 8'h01;

    // Target byte: picked by the access kind; direct and bit kinds also split on address bit 7
    always_comb begin
        ram_addr = acc_addr;
        sfr_addr = acc_addr;
        ram_sel  = 1'b0;
        sfr_sel  = 1'b0;
        bit_ok   = 1'b1;
        case (acc_kind)
            ACC_DIRECT: begin
                if (acc_use_reg) begin
                    ram_addr = bank_base | {5'h00, acc_bit_sel};
                    ram_sel  = 1'b1;
                end else if (acc_addr >= SFR_BASE) begin
                    sfr_sel = 1'b1;
                end else begin
                    ram_sel = 1'b1;
                end
            end
            ACC_INDIRECT: begin
                ram_addr = ind_ptr;
                ram_sel  = 1'b1;
            end
            ACC_BIT: begin
                if (acc_addr[7]) begin
                    sfr_addr = {acc_addr[7:3], 3'h0};
                    sfr_sel  = 1'b1;
                end else begin
                    ram_addr = BIT_ZONE_BASE + {4'h0, acc_addr[6:3]};
                    ram_sel  = 1'b1;
                end
            end
            ACC_PUSH: begin
                ram_addr = sp_plus;
                ram_sel  = 1'b1;
            end
            ACC_POP: begin
                ram_addr = stack_top_pointer_ff;
                ram_sel  = 1'b1;
            end
            default: begin
                bit_ok = 1'b0;
            end
        endcase
    end

    // Internal special registers; the rest go out to user logic
    always_comb begin
        sfr_internal = 1'b1;
        sfr_rd       = UNIMPL_READ;
        case (sfr_addr)
            SP_ADDR:   sfr_rd = stack_top_pointer_ff;
            DPL0_ADDR: sfr_rd = data_pointer_low_primary_ff;
            DPH0_ADDR: sfr_rd = data_pointer_high_primary_ff;
            PTR2_LO_ADDR: sfr_rd = data_pointer_low_secondary_ff;
            PTR2_HI_ADDR: sfr_rd = data_pointer_high_secondary_ff;
            PSEL_ADDR: sfr_rd = {7'h00, pointer_select_ff};
            PSW_ADDR:  sfr_rd = program_status_word_ff;
            ACC_ADDR:  sfr_rd = accumulator_register_ff;
            BREG_ADDR: sfr_rd = operand_b_ff;
            default: begin
                sfr_internal = 1'b0;
                sfr_rd       = ext_sfr_hit ? ext_sfr_rdata : UNIMPL_READ;
            end
        endcase
    end

    // Byte being read, and the merged byte for writes
    assign byte_rd  = ram_sel ? scratch_mem[ram_addr] : sfr_rd;
    assign is_write = acc_write && bit_ok;
    always_comb begin
        nxt_byte = acc_wdata;
        if (acc_kind == ACC_BIT) begin
            nxt_byte = byte_rd;
            nxt_byte[acc_bit_sel] = acc_bit_wval;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Scratchpad memory, no reset so it maps to a RAM
    always_ff @(posedge ref_clk) begin
        if (ram_sel && (is_write || acc_kind == ACC_PUSH)) begin
            scratch_mem[ram_addr] <= (acc_kind == ACC_PUSH) ? acc_wdata : nxt_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stack pointer: anywhere software puts it, wraps inside the memory
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            stack_top_pointer_ff <= SP_RESET;
        end else if (acc_kind == ACC_PUSH) begin
            stack_top_pointer_ff <= sp_plus;
        end else if (acc_kind == ACC_POP) begin
            stack_top_pointer_ff <= stack_top_pointer_ff - 8'h01;
        end else if (sfr_sel && is_write && sfr_addr == SP_ADDR) begin
            stack_top_pointer_ff <= nxt_byte;
        end
    end

    // Data pointers; increment applies only to the active pair
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            data_pointer_low_primary_ff    <= ZERO_RESET;
            data_pointer_high_primary_ff   <= ZERO_RESET;
            data_pointer_low_secondary_ff  <= ZERO_RESET;
            data_pointer_high_secondary_ff <= ZERO_RESET;
            pointer_select_ff              <= 1'b0;
        end else if (active_data_pointer_inc) begin
            if (pointer_select_ff) begin
                {data_pointer_high_secondary_ff, data_pointer_low_secondary_ff} <=
                    active_data_pointer + 16'h0001;
            end else begin
                {data_pointer_high_primary_ff, data_pointer_low_primary_ff} <=
                    active_data_pointer + 16'h0001;
            end
        end else if (sfr_sel && is_write) begin
            // Plain storage whatever the select bit says
            case (sfr_addr)
                DPL0_ADDR: data_pointer_low_primary_ff    <= nxt_byte;
                DPH0_ADDR: data_pointer_high_primary_ff   <= nxt_byte;
                PTR2_LO_ADDR: data_pointer_low_secondary_ff  <= nxt_byte;
                PTR2_HI_ADDR: data_pointer_high_secondary_ff <= nxt_byte;
                PSEL_ADDR: pointer_select_ff              <= nxt_byte[PSEL_BIT];
                default: ;
            endcase
        end
    end

    // Status word: software write wins over the ALU update in the same cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            program_status_word_ff <= ZERO_RESET;
        end else if (sfr_sel && is_write && sfr_addr == PSW_ADDR) begin
            program_status_word_ff <= nxt_byte;
        end else if (alu_psw_we) begin
            program_status_word_ff <= alu_psw_in;
        end
    end

    // Accumulator and secondary operand register
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            accumulator_register_ff <= ZERO_RESET;
            operand_b_ff            <= ZERO_RESET;
        end else begin
            if (sfr_sel && is_write && sfr_addr == ACC_ADDR) begin
                accumulator_register_ff <= nxt_byte;
            end else if (alu_acc_we) begin
                accumulator_register_ff <= alu_acc_in;
            end
            if (sfr_sel && is_write && sfr_addr == BREG_ADDR) begin
                operand_b_ff <= nxt_byte;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs
    assign active_data_pointer = pointer_select_ff ?
        {data_pointer_high_secondary_ff, data_pointer_low_secondary_ff} :
        {data_pointer_high_primary_ff, data_pointer_low_primary_ff};

    // Read data and external strobes land one cycle after the request
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rdata         <= ZERO_RESET;
            rbit          <= 1'b0;
            ext_sfr_req   <= 1'b0;
            ext_sfr_we    <= 1'b0;
            ext_sfr_addr  <= ZERO_RESET;
            ext_sfr_wdata <= ZERO_RESET;
        end else begin
            rdata         <= byte_rd;
            rbit          <= byte_rd[acc_bit_sel];
            ext_sfr_req   <= sfr_sel && !sfr_internal;
            ext_sfr_we    <= sfr_sel && !sfr_internal && is_write;
            ext_sfr_addr  <= sfr_addr;
            ext_sfr_wdata <= nxt_byte;
        end
    end

    // Pointer and operand views for the rest of the core
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            xdata_addr  <= 16'h0000;
            code_addr   <= 16'h0000;
            mul_operand <= ZERO_RESET;
            acc_value   <= ZERO_RESET;
            psw_value   <= ZERO_RESET;
        end else begin
            xdata_addr  <= active_data_pointer;
            code_addr   <= pc_in;
            mul_operand <= operand_b_ff;
            acc_value   <= accumulator_register_ff;
            psw_value   <= program_status_word_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sp_reset_val_a: assert property (@(posedge ref_clk) !rst_b |=> stack_top_pointer_ff == 8'h07)
        else $error("stack pointer reset value wrong");
    push_order_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        acc_kind == ACC_PUSH |=> stack_top_pointer_ff == $past(stack_top_pointer_ff) + 8'h01
            && scratch_mem[stack_top_pointer_ff] == $past(acc_wdata))
        else $error("push order wrong");
    pop_order_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        acc_kind == ACC_POP |=> rdata == $past(scratch_mem[stack_top_pointer_ff])
            && stack_top_pointer_ff == $past(stack_top_pointer_ff) - 8'h01)
        else $error("pop order wrong");
    sfr_direct_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        acc_kind == ACC_INDIRECT |-> !sfr_sel && ram_addr == ind_ptr)
        else $error("indirect access reached special register");
    bank_base_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        acc_kind == ACC_DIRECT && acc_use_reg |-> ram_addr[7:5] == 3'h0
            && ram_addr[4:3] == program_status_word_ff[4:3])
        else $error("bank base wrong");
    bit_zone_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        acc_kind == ACC_BIT && !acc_addr[7] |-> ram_addr == 8'h20 + {4'h0, acc_addr[6:3]})
        else $error("bit zone mapping wrong");
    ptr_select_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        pointer_select_ff && !active_data_pointer_inc && !(sfr_sel && is_write) |=>
            xdata_addr == $past({data_pointer_high_secondary_ff,
                                 data_pointer_low_secondary_ff}))
        else $error("active pointer select wrong");
    port_export_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        sfr_sel && sfr_addr[3:0] == 4'h0 && sfr_addr[7:6] == 2'b10 |=> ext_sfr_req)
        else $error("port access not exported");
    unimpl_ones_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        sfr_sel && !sfr_internal && !ext_sfr_hit |=> rdata == 8'hFF)
        else $error("unimplemented read not all ones");
    psel_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        sfr_sel && sfr_addr == 8'h86 |=> rdata[7:1] == 7'h00)
        else $error("select reserved bits not zero");

    push_pop_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
        acc_kind == ACC_PUSH ##1 acc_kind == ACC_POP);
    bit_sfr_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
        acc_kind == ACC_BIT && acc_addr[7] && is_write);
    second_ptr_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
        pointer_select_ff && active_data_pointer_inc);
    export_c: cover property (@(posedge ref_clk) disable iff (!rst_b) ext_sfr_we);

endmodule : data_space

/* verif/sfr_user_model.sv */
`timescale 1ns/1ps
// User logic holding the exported port slots and one spare slot at C8h
module sfr_user_model (
    input  wire logic                         ref_clk,
    input  wire data_space_pkg::access_kind_e acc_kind,
    input  wire logic [7:0]                   acc_addr,
    input  wire logic                         ext_sfr_req,
    input  wire logic                         ext_sfr_we,
    input  wire logic [7:0]                   ext_sfr_addr,
    input  wire logic [7:0]                   ext_sfr_wdata,
    output logic                              ext_sfr_hit,
    output logic [7:0]                        ext_sfr_rdata
);
    import data_space_pkg::*;

    logic [7:0] port_ff [5];
    logic [7:0] last_ff;
    logic [7:0] badr;

    function automatic int slot_of(input logic [7:0] a);
        return (a == 8'hC8) ? 4 : int'(a[5:4]);
    endfunction : slot_of

    ////////////////////////////////////////////////////////////
    // Answer in the same cycle; a miss shows the inverse of the last data
    always_comb begin
        badr = (acc_kind == ACC_BIT) ? (acc_addr & 8'hF8) : acc_addr;
        ext_sfr_hit = (acc_kind == ACC_DIRECT || acc_kind == ACC_BIT) &&
                      (badr == 8'hC8 || (badr[7:6] == 2'b10 && badr[3:0] == 4'h0));
        ext_sfr_rdata = ext_sfr_hit ? port_ff[slot_of(badr)] : ~last_ff;
    end

    // Capture writes forwarded by the core; plain always since initial also loads these
    always @(posedge ref_clk) begin
        if (ext_sfr_req && ext_sfr_we) begin
            port_ff[slot_of(ext_sfr_addr)] <= ext_sfr_wdata;
        end
        last_ff <= ext_sfr_rdata;
    end

    initial begin
        last_ff = 8'h00;
        for (int i = 0; i < 5; i++) port_ff[i] = 8'h00;
    end
endmodule : sfr_user_model

/* verif/tb.sv */
`timescale 1ns/1ps
// Stands in for the execution unit; reads are checked against a queue of notes
module tb;
    import data_space_pkg::*;

    logic         ref_clk = 1'b0;
    logic         rst_b = 1'b0;
    access_kind_e acc_kind = ACC_NONE;
    logic         acc_write = 1'b0, acc_use_reg = 1'b0, acc_reg_sel = 1'b0;
    logic [2:0]   acc_bit_sel = 3'h0;
    logic [7:0]   acc_addr = 8'h00, acc_wdata = 8'h00, alu_acc_in = 8'h00;
    logic         acc_bit_wval = 1'b0, alu_acc_we = 1'b0, active_data_pointer_inc = 1'b0;
    logic [15:0]  pc_in = 16'h0000;
    logic [7:0]   ext_sfr_rdata, rdata, acc_value, psw_value, mul_operand;
    logic [7:0]   ext_sfr_addr, ext_sfr_wdata;
    logic         ext_sfr_hit, ext_sfr_req, ext_sfr_we, rbit;
    logic [15:0]  xdata_addr, code_addr;
    logic         req_rd = 1'b0, chk_ff = 1'b0;
    logic [8:0]   q [$];
    logic [8:0]   note;
    logic [7:0]   a, b;
    int           n_errors = 0, compares = 0, seed = 14;

    data_space data_space_i (.ref_clk(ref_clk), .rst_b(rst_b), .acc_kind(acc_kind),
        .acc_write(acc_write), .acc_addr(acc_addr), .acc_use_reg(acc_use_reg),
        .acc_reg_sel(acc_reg_sel), .acc_bit_sel(acc_bit_sel), .acc_wdata(acc_wdata),
        .acc_bit_wval(acc_bit_wval), .alu_psw_in(8'h00), .alu_psw_we(1'b0),
        .alu_acc_in(alu_acc_in), .alu_acc_we(alu_acc_we), .active_data_pointer_inc(active_data_pointer_inc),
        .pc_in(pc_in), .ext_sfr_rdata(ext_sfr_rdata), .ext_sfr_hit(ext_sfr_hit),
        .rdata(rdata), .rbit(rbit), .xdata_addr(xdata_addr), .code_addr(code_addr),
        .mul_operand(mul_operand), .acc_value(acc_value), .psw_value(psw_value),
        .ext_sfr_req(ext_sfr_req), .ext_sfr_we(ext_sfr_we),
        .ext_sfr_addr(ext_sfr_addr), .ext_sfr_wdata(ext_sfr_wdata));

    sfr_user_model sfr_user_model_i (.ref_clk(ref_clk), .acc_kind(acc_kind),
        .acc_addr(acc_addr), .ext_sfr_req(ext_sfr_req), .ext_sfr_we(ext_sfr_we),
        .ext_sfr_addr(ext_sfr_addr), .ext_sfr_wdata(ext_sfr_wdata),
        .ext_sfr_hit(ext_sfr_hit), .ext_sfr_rdata(ext_sfr_rdata));

    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out();
        check(16'(q.size()), 16'h0000);
        if (n_errors == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : close_out

    // One request per edge; e[8] set means the bit result is compared
    task automatic op(input access_kind_e k, input logic w, input logic [7:0] ad,
                      input logic [7:0] d, input logic [8:0] e, input logic [4:0] m);
        @(posedge ref_clk);
        acc_kind     <= k;
        acc_write    <= w;
        acc_addr     <= ad;
        acc_wdata    <= d;
        acc_bit_wval <= d[0];
        acc_use_reg  <= m[4];
        acc_reg_sel  <= m[3];
        acc_bit_sel  <= (k == ACC_BIT) ? ad[2:0] : m[2:0];
        req_rd       <= !w;
        if (!w) q.push_back(e);
    endtask : op

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        op(ACC_DIRECT, 1'b1, ad, d, 9'h000, 5'h00);
    endtask : wr

    task automatic rd(input logic [7:0] ad, input logic [7:0] e);
        op(ACC_DIRECT, 1'b0, ad, 8'h00, {1'b0, e}, 5'h00);
    endtask : rd

    task automatic idle(input int n);
        @(posedge ref_clk);
        acc_kind  <= ACC_NONE;
        acc_write <= 1'b0;
        req_rd    <= 1'b0;
        repeat (n - 1) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : idle

    ////////////////////////////////////////////////////////////
    // Results land one cycle after the request is taken, so check on the falling edge
    always @(posedge ref_clk) chk_ff <= req_rd;

    always @(negedge ref_clk) begin
        if (chk_ff === 1'b1) begin
            note = q.pop_front();
            if (note[8]) check({15'h0, rbit}, {15'h0, note[0]});
            else check({8'h00, rdata}, {8'h00, note[7:0]});
        end
    end

    // Guards against a hung sequence
    initial begin
        #1000000;
        n_errors++;
        close_out();
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 6; i++) rd(8'(8'h81 + i), (i == 0) ? 8'h07 : 8'h00);
        for (int i = 0; i < 5; i++) begin
            a = 8'($random(seed));
            wr(8'(8'h81 + i), a);
            rd(8'(8'h81 + i), a);
        end
        wr(8'h86, 8'hFF);
        rd(8'h86, 8'h01);
        wr(8'h86, 8'h00);
        // Exported slots: ports, a spare address, and a miss that reads as ones
        for (int i = 0; i < 4; i++) wr(8'(8'h80 + 16 * i), 8'(8'h3C + i));
        wr(8'hC8, 8'h77);
        idle(2);
        for (int i = 0; i < 4; i++) rd(8'(8'h80 + 16 * i), 8'(8'h3C + i));
        rd(8'hC8, 8'h77);
        rd(8'h87, 8'hFF);
        // Indirect through both pointers lands in upper scratchpad, not the ports
        wr(8'h00, 8'h90);
        wr(8'h01, 8'hA0);
        op(ACC_INDIRECT, 1'b1, 8'h00, 8'hC3, 9'h000, 5'h00);
        op(ACC_INDIRECT, 1'b1, 8'h00, 8'h5A, 9'h000, 5'h08);
        op(ACC_INDIRECT, 1'b0, 8'h00, 8'h00, 9'h0C3, 5'h00);
        op(ACC_INDIRECT, 1'b0, 8'h00, 8'h00, 9'h05A, 5'h08);
        rd(8'h90, 8'h3D);
        rd(8'hA0, 8'h3E);
        for (int n = 0; n < 4; n++) begin
            a = 8'($random(seed));
            wr(8'hD0, 8'(n << 3));
            op(ACC_DIRECT, 1'b1, 8'h00, a, 9'h000, 5'h17);
            rd(8'(n * 8 + 7), a);
            idle(2);
            check({14'h0, psw_value[4:3]}, 16'(n));
        end
        wr(8'hD0, 8'h00);
        // Bit zone: bit address 1Bh and the last bit address, then a bit of the accumulator
        wr(8'h23, 8'h00);
        op(ACC_BIT, 1'b1, 8'h1B, 8'h01, 9'h000, 5'h00);
        op(ACC_BIT, 1'b0, 8'h1B, 8'h00, 9'h101, 5'h00);
        rd(8'h23, 8'h08);
        wr(8'h2F, 8'hFF);
        op(ACC_BIT, 1'b1, 8'h7F, 8'h00, 9'h000, 5'h00);
        rd(8'h2F, 8'h7F);
        wr(8'hE0, 8'h00);
        op(ACC_BIT, 1'b1, 8'hE3, 8'h01, 9'h000, 5'h00);
        rd(8'hE0, 8'h08);
        idle(2);
        check({8'h00, acc_value}, 16'h0008);
        @(posedge ref_clk);
        alu_acc_in <= 8'h5A;
        alu_acc_we <= 1'b1;
        @(posedge ref_clk);
        alu_acc_we <= 1'b0;
        rd(8'hE0, 8'h5A);
        // Stack placed away from its reset spot
        a = 8'($random(seed));
        b = 8'($random(seed));
        wr(8'h81, 8'h30);
        op(ACC_PUSH, 1'b1, 8'h00, a, 9'h000, 5'h00);
        op(ACC_PUSH, 1'b1, 8'h00, b, 9'h000, 5'h00);
        rd(8'h31, a);
        rd(8'h32, b);
        rd(8'h81, 8'h32);
        op(ACC_POP, 1'b0, 8'h00, 8'h00, {1'b0, b}, 5'h00);
        op(ACC_POP, 1'b0, 8'h00, 8'h00, {1'b0, a}, 5'h00);
        rd(8'h81, 8'h30);
        // Pointer pairs, selection and increment
        wr(8'h82, 8'h34);
        wr(8'h83, 8'h12);
        wr(8'h85, 8'hAB);
        wr(8'h84, 8'hCD);
        idle(3);
        check(xdata_addr, 16'h1234);
        wr(8'h86, 8'h01);
        idle(3);
        check(xdata_addr, 16'hABCD);
        @(posedge ref_clk);
        active_data_pointer_inc <= 1'b1;
        @(posedge ref_clk);
        active_data_pointer_inc <= 1'b0;
        idle(2);
        check(xdata_addr, 16'hABCE);
        wr(8'h86, 8'h00);
        idle(3);
        check(xdata_addr, 16'h1234);
        rd(8'h84, 8'hCE);
        a = 8'($random(seed));
        wr(8'hF0, a);
        rd(8'hF0, a);
        idle(2);
        check({8'h00, mul_operand}, {8'h00, a});
        @(posedge ref_clk);
        pc_in <= 16'($random(seed));
        idle(2);
        check(code_addr, pc_in);
        // Second reset in mid-run must restore the pointer values
        @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        rd(8'h81, 8'h07);
        rd(8'h84, 8'h00);
        idle(2);
        check(xdata_addr, 16'h0000);
        close_out();
    end
endmodule : tb
